// file: design/pdt_pkg.sv
// Notes on behaviour
// - Writing the prescaler reset bit one clears the timer prescaler.
// - Each timer tick clears, increments or decrements; reaching zero is flagged.
// - Timer clock from system or fast clock; clock select zero stops it.
// - Counter always accessible; CPU write beats clear or count.
// - Counter compared continuously with all four compare registers.
// - Match on A, B or D sets its flag one timer tick later.
// - Enabled flag raises interrupt; cleared by service or writing one.
// - PWM modes double buffer compare registers; normal mode writes directly.
// - Reading a buffered compare register returns the pending value.
// - Non-PWM force strobe acts like a match without flag or clear.
// - Counter write blocks matches on A, B and D in the following timer tick.
// - Compare outputs keep their level across waveform mode changes.
// - Output mode bits are not buffered and act at once.
// - Dead time only in PWM with output mode 01.
// - Three dead-time generators make non-overlapping output pairs.
// - Dead-time prescaler divides source clock by 1, 2, 4 or 8.
// - Waveform edge starts 4-bit down counter; rising output held until zero.
// - Rising edge loads upper dead-time field, falling edge the lower.
// - With zero dead time, pairs still lag the waveform by two ticks.
// - Inversion bit inverts both pair outputs, both high in dead time.
// - Register top is clear value; A, B, D drive outputs and flags.
package pdt_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PRESC_W = 14;
  localparam int unsigned DT_W = 4;
  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL_A = 4'h0;
  localparam logic [3:0] OFS_CTRL_B = 4'h1;
  localparam logic [3:0] OFS_CTRL_C = 4'h2;
  localparam logic [3:0] OFS_CTRL_D = 4'h3;
  localparam logic [3:0] OFS_FLAGS = 4'h4;
  localparam logic [3:0] OFS_PLL = 4'h5;
  localparam logic [3:0] OFS_COUNT = 4'h6;
  localparam logic [3:0] OFS_CMP_A = 4'h7;
  localparam logic [3:0] OFS_CMP_B = 4'h8;
  localparam logic [3:0] OFS_CMP_TOP = 4'h9;
  localparam logic [3:0] OFS_CMP_D = 4'hA;
  localparam logic [3:0] OFS_DEAD = 4'hB;
  localparam logic [3:0] OFS_DT_PRESC = 4'hC;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned B_PWM_A = 6;
  localparam int unsigned B_PWM_B = 7;
  localparam int unsigned B_PSC_RST = 6;
  localparam int unsigned B_INVERT = 7;
  localparam int unsigned B_PWM_D = 0;
  localparam int unsigned B_WGM_LO = 1;
  localparam int unsigned B_FORCE_LO = 4;
  localparam int unsigned B_OVF = 3;
  localparam int unsigned B_LOCK = 7;
  localparam int unsigned B_FAST_EN = 0;
  // ----------------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_TOP = 8'hFF;
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  localparam logic [1:0] WGM_FAST = 2'h0;
  localparam logic [1:0] WGM_DUAL = 2'h1;
  typedef enum logic [1:0] {
    PDT_UP = 2'b01,
    PDT_DOWN = 2'b10
  } pdt_dir_t;
  typedef struct packed {
    logic true_lvl;
    logic comp_lvl;
  } pdt_pair_t;
endpackage

// file: design/pdt_presc.sv
`timescale 1ns/100ps
module pdt_presc #(
  parameter int unsigned CW = pdt_pkg::PRESC_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic src_tick_i,
  input wire logic clear_i,
  input wire logic [3:0] sel_i,
  output logic tick_o
);
  import pdt_pkg::*;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] mask;
  if (CW < 14) begin : g_width_chk
    $error("prescaler narrower than 14 bits");
  end
  assign mask = (sel_i == 4'h0) ? '0 : CW'((32'h1 << (sel_i - 4'h1)) - 1);
  // Divide by 2^(sel-1), zero selection stops
  assign tick_o = (sel_i != 4'h0) && src_tick_i && ((cnt_q & mask) == mask);
  assign cnt_d = clear_i ? '0 : (src_tick_i ? cnt_q + 1'b1 : cnt_q);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cnt_q <= '0;
    else cnt_q <= cnt_d;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_presc_clear: assert property (clear_i |=> cnt_q == '0)
    else $error("prescaler not cleared");
endmodule

// file: design/pdt_deadtime.sv
`timescale 1ns/100ps
module pdt_deadtime (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic tick_i,
  input wire logic dt_tick_i,
  input wire logic wave_i,
  input wire logic dt_en_i,
  input wire logic invert_i,
  input wire logic [pdt_pkg::DT_W-1:0] rise_i,
  input wire logic [pdt_pkg::DT_W-1:0] fall_i,
  output pdt_pkg::pdt_pair_t pair_o
);
  import pdt_pkg::*;
  logic wave_q;
  logic [DT_W-1:0] cnt_q;
  logic [DT_W-1:0] cnt_d;
  logic edge_seen;
  logic zero;
  pdt_pair_t pair_d;
  assign edge_seen = tick_i && (wave_i != wave_q);
  assign zero = (cnt_q == '0) || !dt_en_i;
  assign cnt_d = edge_seen ? (wave_i ? rise_i : fall_i) :
    ((dt_tick_i && cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
  // Rising side of each output waits for zero count
  assign pair_d.true_lvl = (wave_q & zero) ^ invert_i;
  assign pair_d.comp_lvl = (dt_en_i ? (~wave_q & zero) : ~wave_q) ^ invert_i;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wave_q <= 1'b0;
      cnt_q <= '0;
      pair_o <= '0;
    end else begin
      cnt_q <= cnt_d;
      if (tick_i) wave_q <= wave_i;
      if (tick_i) pair_o <= pair_d;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_hold_rise: assert property (
    (cnt_q != '0 && dt_en_i && !invert_i) |=> !$rose(pair_o.true_lvl))
    else $error("true output rose during dead time");
  a_no_overlap: assert property (
    (dt_en_i && !invert_i) |-> ##1 !(pair_o.true_lvl && pair_o.comp_lvl))
    else $error("pair outputs overlap");
endmodule

// file: design/pdt_core.sv
`timescale 1ns/100ps
module pdt_core #(
  parameter int unsigned CNT_W = pdt_pkg::DATA_W
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [pdt_pkg::ADDR_W-1:0] addr_i,
  input wire logic [pdt_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [pdt_pkg::DATA_W-1:0] rdata_o,
  input wire logic fast_clk_i,
  input wire logic pll_lock_i,
  input wire logic [3:0] irq_ack_i,
  output logic irq_o,
  output logic [2:0] wave_o,
  output pdt_pkg::pdt_pair_t [2:0] pair_o
);
  import pdt_pkg::*;
  if (CNT_W != DATA_W) begin : g_width_chk
    $error("counter width must equal data width");
  end
  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0] ctrl_a_q, ctrl_b_q, ctrl_c_q, ctrl_d_q;
  logic [7:0] dead_q;
  logic [1:0] dt_presc_q;
  logic fast_en_q;
  logic [3:0] flag_q, flag_d;
  logic [7:0] cnt_q, cnt_d, cnt_nx;
  logic [7:0] buf_q [4];
  logic [7:0] act_q [4];
  logic blk_q;
  logic irq_q;
  logic [7:0] rdata_q;
  logic [2:0] wave_q, wave_d;
  pdt_dir_t dir_q, dir_d;
  logic fsync1_q, fsync2_q, fsync3_q;
  logic lsync1_q, lsync2_q;
  logic [2:0] dtc_q;
  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  wire wr_a = wr_i && addr_i == OFS_CTRL_A;
  wire wr_b = wr_i && addr_i == OFS_CTRL_B;
  wire wr_c = wr_i && addr_i == OFS_CTRL_C;
  wire wr_d = wr_i && addr_i == OFS_CTRL_D;
  wire wr_flag = wr_i && addr_i == OFS_FLAGS;
  wire wr_pll = wr_i && addr_i == OFS_PLL;
  wire wr_cnt = wr_i && addr_i == OFS_COUNT;
  wire wr_dead = wr_i && addr_i == OFS_DEAD;
  wire wr_dtp = wr_i && addr_i == OFS_DT_PRESC;
  wire [3:0] wr_cmp = {wr_i && addr_i == OFS_CMP_D,
    wr_i && addr_i == OFS_CMP_TOP, wr_i && addr_i == OFS_CMP_B,
    wr_i && addr_i == OFS_CMP_A};
  wire [2:0][1:0] com = {ctrl_a_q[5:4], ctrl_a_q[3:2], ctrl_a_q[1:0]};
  wire [2:0] pwm_en = {ctrl_c_q[B_PWM_D], ctrl_a_q[B_PWM_B],
    ctrl_a_q[B_PWM_A]};
  wire pwm_any = |pwm_en;
  wire [1:0] wgm = ctrl_c_q[B_WGM_LO+1:B_WGM_LO];
  wire dual = pwm_any && wgm == WGM_DUAL;
  wire [2:0] force_s = (wr_c && !pwm_any) ?
    wdata_i[B_FORCE_LO+2:B_FORCE_LO] : 3'h0;
  wire invert = ctrl_b_q[B_INVERT];
  // --------------------------------------------------------------------
  // Clock source and prescalers
  // --------------------------------------------------------------------
  wire fast_edge = fsync2_q && !fsync3_q;
  wire src_tick = fast_en_q ? fast_edge : 1'b1;
  wire tick;
  wire [2:0] dt_mask = 3'((4'h1 << dt_presc_q) - 4'h1);
  wire dt_tick = src_tick && ((dtc_q & dt_mask) == dt_mask);
  pdt_presc u_presc (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .src_tick_i(src_tick),
    .clear_i(wr_b && wdata_i[B_PSC_RST]),
    .sel_i(ctrl_b_q[3:0]),
    .tick_o(tick)
  );
  // --------------------------------------------------------------------
  // Counter unit
  // --------------------------------------------------------------------
  wire [7:0] top = act_q[2];
  wire at_top = cnt_q == top;
  wire at_bot = cnt_q == 8'h00;
  always_comb begin
    dir_d = dir_q;
    cnt_nx = cnt_q + 8'h01;
    if (!dual) begin
      dir_d = PDT_UP;
      if (at_top) cnt_nx = 8'h00;
    end else begin
      case (dir_q)
        PDT_UP: begin
          if (at_top) begin
            dir_d = PDT_DOWN;
            cnt_nx = at_bot ? cnt_q : cnt_q - 8'h01;
          end
        end
        PDT_DOWN: begin
          if (at_bot) dir_d = PDT_UP;
          else cnt_nx = cnt_q - 8'h01;
        end
        default: dir_d = PDT_UP;
      endcase
    end
  end
  // CPU write wins over counting
  assign cnt_d = wr_cnt ? wdata_i : (tick ? cnt_nx : cnt_q);
  wire ovf_set = tick && !wr_cnt && cnt_nx == 8'h00;
  // Buffered compare update point
  wire upd = tick && (dual ? at_bot : at_top);
  // --------------------------------------------------------------------
  // Compare and waveform
  // --------------------------------------------------------------------
  wire [3:0] cmp_eq;
  wire [2:0] match;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cmp
      assign cmp_eq[g] = cnt_q == act_q[g];
    end
    for (g = 0; g < 3; g++) begin : g_ch
      localparam int unsigned IX = (g == 2) ? 3 : g;
      assign match[g] = tick && !blk_q && cmp_eq[IX];
      always_comb begin
        wave_d[g] = wave_q[g];
        if (force_s[g] || (match[g] && !pwm_any)) begin
          case (com[g])
            COM_TOGGLE: wave_d[g] = !wave_q[g];
            COM_CLEAR: wave_d[g] = 1'b0;
            COM_SET: wave_d[g] = 1'b1;
            default: wave_d[g] = wave_q[g];
          endcase
        end else if (pwm_any && com[g] != COM_OFF) begin
          if (dual && match[g]) begin
            wave_d[g] = (com[g] == COM_SET) ^ (dir_q == PDT_DOWN);
          end else if (!dual && match[g]) begin
            wave_d[g] = com[g] == COM_SET;
          end else if (!dual && tick && at_top) begin
            wave_d[g] = com[g] != COM_SET;
          end
        end
      end
      pdt_deadtime u_dt (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .tick_i(tick),
        .dt_tick_i(dt_tick),
        .wave_i(wave_q[g]),
        .dt_en_i(pwm_en[g] && com[g] == COM_TOGGLE),
        .invert_i(invert),
        .rise_i(dead_q[7:4]),
        .fall_i(dead_q[3:0]),
        .pair_o(pair_o[g])
      );
    end
  endgenerate
  // --------------------------------------------------------------------
  // Flags and interrupt
  // --------------------------------------------------------------------
  wire [3:0] flag_set = {ovf_set, match[2], match[1], match[0]};
  wire [3:0] flag_clr = irq_ack_i | (wr_flag ? wdata_i[3:0] : 4'h0);
  assign flag_d = (flag_q & ~flag_clr) | flag_set;
  // --------------------------------------------------------------------
  // Read mux
  // --------------------------------------------------------------------
  wire [7:0] rd_mux =
    (addr_i == OFS_CTRL_A) ? ctrl_a_q :
    (addr_i == OFS_CTRL_B) ? {ctrl_b_q[7], 1'b0, 2'b00, ctrl_b_q[3:0]} :
    (addr_i == OFS_CTRL_C) ? {5'h00, ctrl_c_q[2:0]} :
    (addr_i == OFS_CTRL_D) ? {4'h0, ctrl_d_q[3:0]} :
    (addr_i == OFS_FLAGS) ? {4'h0, flag_q} :
    (addr_i == OFS_PLL) ? {lsync2_q, 6'h00, fast_en_q} :
    (addr_i == OFS_COUNT) ? cnt_q :
    (addr_i == OFS_CMP_A) ? buf_q[0] :
    (addr_i == OFS_CMP_B) ? buf_q[1] :
    (addr_i == OFS_CMP_TOP) ? buf_q[2] :
    (addr_i == OFS_CMP_D) ? buf_q[3] :
    (addr_i == OFS_DEAD) ? dead_q :
    (addr_i == OFS_DT_PRESC) ? {6'h00, dt_presc_q} : 8'h00;
  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_a_q <= RST_REG;
      ctrl_b_q <= RST_REG;
      ctrl_c_q <= RST_REG;
      ctrl_d_q <= RST_REG;
      dead_q <= RST_REG;
      dt_presc_q <= 2'h0;
      fast_en_q <= 1'b0;
      flag_q <= 4'h0;
      cnt_q <= RST_REG;
      dir_q <= PDT_UP;
      blk_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= RST_REG;
      wave_q <= 3'h0;
      dtc_q <= 3'h0;
    end else begin
      if (wr_a) ctrl_a_q <= wdata_i;
      if (wr_b) ctrl_b_q <= wdata_i & 8'hBF;
      if (wr_c) ctrl_c_q <= wdata_i & 8'h07;
      if (wr_d) ctrl_d_q <= wdata_i & 8'h0F;
      if (wr_dead) dead_q <= wdata_i;
      if (wr_dtp) dt_presc_q <= wdata_i[1:0];
      if (wr_pll) fast_en_q <= wdata_i[B_FAST_EN];
      flag_q <= flag_d;
      cnt_q <= cnt_d;
      if (tick) dir_q <= dir_d;
      blk_q <= wr_cnt || (blk_q && !tick);
      irq_q <= |(flag_q & ctrl_d_q[3:0]);
      rdata_q <= rd_i ? rd_mux : 8'h00;
      wave_q <= wave_d;
      if (src_tick) dtc_q <= dtc_q + 3'h1;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 4; i++) begin
        buf_q[i] <= (i == 2) ? RST_TOP : RST_REG;
        act_q[i] <= (i == 2) ? RST_TOP : RST_REG;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_cmp[i]) buf_q[i] <= wdata_i;
        if (wr_cmp[i] && !pwm_any) act_q[i] <= wdata_i;
        else if (upd && pwm_any) act_q[i] <= buf_q[i];
      end
    end
  end
  // Fast clock and lock pin synchronisers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fsync1_q <= 1'b0;
      fsync2_q <= 1'b0;
      fsync3_q <= 1'b0;
      lsync1_q <= 1'b0;
      lsync2_q <= 1'b0;
    end else begin
      fsync1_q <= fast_clk_i;
      fsync2_q <= fsync1_q;
      fsync3_q <= fsync2_q;
      lsync1_q <= pll_lock_i;
      lsync2_q <= lsync1_q;
    end
  end
  assign rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign wave_o = wave_q;
  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_count_write_wins: assert property (
    wr_cnt |=> cnt_q == $past(wdata_i))
    else $error("counter write lost");
  a_stopped_holds: assert property (
    (ctrl_b_q[3:0] == 4'h0 && !wr_cnt && !wr_b) |=> $stable(cnt_q))
    else $error("counter moved while stopped");
  a_match_blocked: assert property (
    (wr_cnt ##1 tick) |-> match == 3'h0)
    else $error("match after counter write");
  a_flag_a_sets: assert property (
    (tick && !blk_q && cnt_q == act_q[0]) |=> flag_q[0])
    else $error("flag a not set on match");
  a_flag_w1c: assert property (
    (wr_flag && wdata_i[1] && !match[1]) |=> !flag_q[1])
    else $error("flag b not cleared");
  a_pending_read: assert property (
    (pwm_any && wr_cmp[0] && !upd) ##1 (!wr_cmp[0] && !upd)
      ##1 (rd_i && addr_i == OFS_CMP_A)
      |=> rdata_o == $past(wdata_i, 3))
    else $error("pending compare not read back");
  a_normal_bypass: assert property (
    (!pwm_any && wr_cmp[1]) |=> act_q[1] == $past(wdata_i))
    else $error("normal mode compare not direct");
  a_force_noflag: assert property (
    (force_s[0] && !match[0]) |=> !$rose(flag_q[0]))
    else $error("force set a flag");
  a_top_wrap: assert property (
    (tick && !dual && at_top && !wr_cnt) |=> cnt_q == 8'h00)
    else $error("counter did not clear at top");
  a_dual_turn: assert property (
    (tick && dual && dir_q == PDT_UP && at_top && !at_bot && !wr_cnt)
      |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("dual slope did not turn at top");
  a_bottom_turn: assert property (
    (tick && dual && dir_q == PDT_DOWN && at_bot && !at_top && !wr_cnt)
      |=> cnt_q == 8'h01)
    else $error("dual slope did not turn at bottom");
  a_ovf_flag: assert property (
    ovf_set |=> flag_q[3])
    else $error("overflow flag not set");
  a_idle_holds: assert property (
    (!wr_cnt && !tick) |=> $stable(cnt_q))
    else $error("counter moved without tick");
  a_fast_source: assert property (
    (fast_en_q && !fast_edge) |-> !tick)
    else $error("tick without fast clock edge");
  a_stop_no_match: assert property (
    (ctrl_b_q[3:0] == 4'h0) |-> match == 3'h0)
    else $error("match while stopped");
  a_irq_raise: assert property (
    (|(flag_q & ctrl_d_q[3:0])) |=> irq_o)
    else $error("enabled flag gave no interrupt");
  a_ack_clears: assert property (
    (irq_ack_i[2] && !match[2]) |=> !flag_q[2])
    else $error("serviced flag not cleared");
  a_buf_update: assert property (
    (pwm_any && upd) |=> act_q[0] == $past(buf_q[0]))
    else $error("buffered compare not loaded");
  a_pwm_holds: assert property (
    (pwm_any && !upd) |=> $stable(act_q[1]))
    else $error("buffered compare moved early");
  a_force_set: assert property (
    (force_s[0] && com[0] == COM_SET) |=> wave_q[0])
    else $error("forced set not applied");
  a_force_clear: assert property (
    (force_s[1] && com[1] == COM_CLEAR) |=> !wave_q[1])
    else $error("forced clear not applied");
  a_mode_live: assert property (
    (!pwm_any && match[0] && com[0] == COM_CLEAR) |=> !wave_q[0])
    else $error("output mode not applied at once");
  a_mode_keeps: assert property (
    (wr_c && !tick && force_s == 3'h0) |=> $stable(wave_q))
    else $error("waveform moved on mode write");
  a_rdata_idle: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data not idle");
  // --------------------------------------------------------------------
  // Cover properties
  // --------------------------------------------------------------------
  c_overflow: cover property (tick && ovf_set);
  c_dual_turn: cover property (tick && dual && dir_q == PDT_DOWN && at_bot);
  c_force: cover property (force_s != 3'h0);
  c_blocked: cover property (tick && blk_q && cmp_eq != 4'h0);
  c_dead_gap: cover property (tick && !pair_o[0].true_lvl &&
    !pair_o[0].comp_lvl);
endmodule

// file: bench/pdt_core_tb.sv
`timescale 1ns/100ps
module pdt_core_tb;
  import pdt_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic fast_clk_i = 1'b0;
  logic pll_lock_i = 1'b0;
  logic [3:0] irq_ack_i = 4'h0;
  logic irq_o;
  logic [2:0] wave_o;
  pdt_pair_t [2:0] pair_o;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int run_len = 0;
  int max_run = 0;
  int hi_cnt = 0;
  int lo_cnt = 0;
  logic [7:0] v;
  logic [1:0] codes [5] = '{COM_SET, COM_OFF, COM_TOGGLE, COM_TOGGLE,
    COM_CLEAR};
  logic exp_w [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  pdt_core u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .fast_clk_i(fast_clk_i), .pll_lock_i(pll_lock_i),
    .irq_ack_i(irq_ack_i), .irq_o(irq_o), .wave_o(wave_o),
    .pair_o(pair_o)
  );

  always #20 clk_i = ~clk_i;
  // Fast source, unrelated in phase and slower than the system clock
  always #53 fast_clk_i = ~fast_clk_i;

  // ----------------------------------------------------------------------
  // Pair monitor and timeout
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (pair_o[0].true_lvl === pair_o[0].comp_lvl) run_len++;
    else run_len = 0;
    if (run_len > max_run) max_run = run_len;
    if (pair_o[0].true_lvl === 1'b1 && pair_o[0].comp_lvl === 1'b1) hi_cnt++;
    if (pair_o[0].true_lvl === 1'b0 && pair_o[0].comp_lvl === 1'b0) lo_cnt++;
    if (cycles == 60000) begin
      error_cnt++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check8(d, exp);
  endtask

  task automatic measure();
    repeat (300) @(posedge clk_i);
    @(negedge clk_i);
    run_len = 0;
    max_run = 0;
    hi_cnt = 0;
    lo_cnt = 0;
    repeat (600) @(posedge clk_i);
  endtask

  task automatic conclude();
    $display("error_cnt=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdchk(OFS_CMP_TOP, RST_TOP);
    rdchk(OFS_DEAD, RST_REG);
    rdchk(OFS_CMP_A, RST_REG);
    rdchk(4'hD, 8'h00);
    wr(4'hD, 8'h5A);
    rdchk(4'hD, 8'h00);
    wr(OFS_DEAD, 8'hA5);
    rdchk(OFS_DEAD, 8'hA5);
    wr(OFS_COUNT, 8'h10);
    repeat (20) @(posedge clk_i);
    rdchk(OFS_COUNT, 8'h10);
    wr(OFS_CTRL_B, 8'h40);
    rdchk(OFS_CTRL_B, 8'h00);
    // Short top: counter must wrap and flag overflow
    wr(OFS_CMP_TOP, 8'h03);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CTRL_B, 8'h01);
    for (int i = 0; i < 8; i++) begin
      rd(OFS_COUNT, v);
      check1(v <= 8'h03, 1'b1);
    end
    wr(OFS_CTRL_B, 8'h00);
    rd(OFS_FLAGS, v);
    check1(v[B_OVF], 1'b1);
    wr(OFS_FLAGS, 8'h0F);
    rdchk(OFS_FLAGS, 8'h00);
    // Matches on A and D, none on B
    wr(OFS_CMP_TOP, 8'hFF);
    wr(OFS_CMP_A, 8'h05);
    wr(OFS_CMP_B, 8'h80);
    wr(OFS_CMP_D, 8'h06);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CTRL_D, 8'h01);
    wr(OFS_CTRL_B, 8'h01);
    repeat (20) @(posedge clk_i);
    wr(OFS_CTRL_B, 8'h00);
    rdchk(OFS_FLAGS, 8'h05);
    check1(irq_o, 1'b1);
    @(posedge clk_i);
    irq_ack_i <= 4'h1;
    @(posedge clk_i);
    irq_ack_i <= 4'h0;
    repeat (2) @(posedge clk_i);
    #1;
    check1(irq_o, 1'b0);
    rdchk(OFS_FLAGS, 8'h04);
    wr(OFS_FLAGS, 8'h04);
    rdchk(OFS_FLAGS, 8'h00);
    // Counter written equal to compare: match must be blocked
    wr(OFS_CMP_A, 8'h30);
    wr(OFS_COUNT, 8'h30);
    wr(OFS_CTRL_B, 8'h01);
    repeat (10) @(posedge clk_i);
    wr(OFS_CTRL_B, 8'h00);
    rdchk(OFS_FLAGS, 8'h00);
    // Forced compare, every output mode
    for (int i = 0; i < 5; i++) begin
      wr(OFS_CTRL_A, {6'h00, codes[i]});
      wr(OFS_CTRL_C, 8'h10);
      check1(wave_o[0], exp_w[i]);
    end
    rdchk(OFS_FLAGS, 8'h00);
    wr(OFS_CTRL_A, {6'h00, COM_SET});
    wr(OFS_CTRL_C, 8'h10);
    check1(wave_o[0], 1'b1);
    check1(pair_o[0].true_lvl, 1'b0);
    wr(OFS_CTRL_B, 8'h01);
    repeat (4) @(posedge clk_i);
    #1;
    check1(pair_o[0].true_lvl, 1'b1);
    check1(pair_o[0].comp_lvl, 1'b0);
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_C, 8'h02);
    check1(wave_o[0], 1'b1);
    // PWM: buffered compare reads pending value, force ignored
    wr(OFS_CTRL_C, 8'h00);
    wr(OFS_CTRL_A, 8'h41);
    check1(wave_o[0], 1'b1);
    wr(OFS_CMP_A, 8'h40);
    rdchk(OFS_CMP_A, 8'h40);
    wr(OFS_CTRL_C, 8'h10);
    check1(wave_o[0], 1'b1);
    // Dead time, every prescale
    wr(OFS_DEAD, 8'h32);
    wr(OFS_CTRL_B, 8'h01);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_DT_PRESC, p[7:0]);
      measure();
      check1(hi_cnt == 0, 1'b1);
      check1(max_run >= (2 << p) + 1, 1'b1);
      check1(max_run <= (3 << p), 1'b1);
    end
    wr(OFS_CTRL_B, 8'h81);
    measure();
    check1(lo_cnt == 0, 1'b1);
    check1(hi_cnt > 0, 1'b1);
    wr(OFS_CTRL_B, 8'h01);
    wr(OFS_CTRL_A, 8'h42);
    measure();
    check1(max_run == 0, 1'b1);
    wr(OFS_CTRL_B, 8'h00);
    // Dual slope: turns at top, overflow flagged at bottom
    wr(OFS_CMP_TOP, 8'h03);
    wr(OFS_CTRL_C, 8'h02);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_FLAGS, 8'h0F);
    wr(OFS_CTRL_B, 8'h01);
    for (int i = 0; i < 8; i++) begin
      rd(OFS_COUNT, v);
      check1(v <= 8'h03, 1'b1);
    end
    wr(OFS_CTRL_B, 8'h00);
    rd(OFS_FLAGS, v);
    check1(v[B_OVF], 1'b1);
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_CMP_TOP, 8'hFF);
    // Fast clock enable after lock
    pll_lock_i <= 1'b1;
    repeat (2500) @(posedge clk_i);
    v = 8'h00;
    for (int i = 0; i < 10 && v[B_LOCK] !== 1'b1; i++) begin
      rd(OFS_PLL, v);
    end
    wr(OFS_PLL, 8'h01);
    rdchk(OFS_PLL, 8'h81);
    wr(OFS_COUNT, 8'h00);
    wr(OFS_CTRL_B, 8'h01);
    repeat (40) @(posedge clk_i);
    wr(OFS_CTRL_B, 8'h00);
    rd(OFS_COUNT, v);
    check1(v >= 8'h0A && v <= 8'h14, 1'b1);
    conclude();
  end
endmodule
